// file: src/rx_hdlc_channel_indirect_access.sv
// Receive HDLC processor for 84 links with indirect channel access over AHB-Lite
// Behaviour
// - Channel select holds group 1..3 in bits 6:5 and tributary 1..28 in 4:0.
// - FIFO-access bit 1 targets the packet FIFO, 0 the configuration context.
// - Data register reads return the latest indirect read; only a configuration write copies staged bits 4:1 into it.
// - Enable 1 receives packets; enable 0 clears FIFO, flags and event bit.
// - Delineate on strips flags and stuffing; off stores the raw stream unchecked.
// - Check select 00 none, 01 16-bit, 10 32-bit, 11 illegal; ignored without delineation.
// - Delineate, check select and invert read back written values until a read.
// - Invert 1 complements every incoming bit before HDLC processing.
// - Each channel buffers 127 bytes, check sequence included, flags excluded.
// - Bit order 0 puts first bit in bit 0, 1 puts it in bit 7.
// - Match enabled stores only packets whose first byte matches an address or all ones.
// - Match mask drops the two low bits from every address comparison.
// - First byte after a flag is compared, msb first, and stored when matching.
// - Each FIFO byte carries a three-bit status code.
// - Abort pattern writes one dummy byte marked with the abort code.
// - Packet-in sets with the event bit on packet end or abort; read clears.
// - Overrun sets with the event bit, empties the FIFO, holds until read.
// - Empty flag sets when the last entry is read, clears when data arrives.
// - FIFO mode returns the byte, then busy, empty, overrun, packet-in and status.
// - Writing the status register starts an access; busy holds until done.
// - Busy lasts at most 86 cycles, mean below 9; here one cycle, but a FIFO-mode write holds it until the next status write.
// - An indirect FIFO read returning empty also clears the channel event bit.
`timescale 1ns/10ps
`default_nettype none
module rx_hdlc_channel_indirect_access (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        rx_valid,
  input  wire logic [6:0]  rx_channel,
  input  wire logic        rx_bit
);
  localparam int NCH = rx_hdlc_pkg::NUM_CHANNELS;
  localparam int DEPTH = 1 << rx_hdlc_pkg::FIFO_PTR_W;

  typedef struct packed {
    rx_hdlc_pkg::acc_state_t acc;
    logic                    rw;
    logic [7:0]              chsel;
    logic [31:0]             stage;
    logic [31:0]             res;
    logic                    res_fifo;
    logic                    order;
    logic                    ap_wr;
    logic [9:0]              ap_idx;
    logic [31:0]             rdata;
  } ctl_t;

  ctl_t                        s_r;
  ctl_t                        s_nxt;
  rx_hdlc_pkg::chan_ctx_t      ctx_mem  [0:NCH-1];
  logic [31:0]                 cfg_mem  [0:NCH-1];
  logic [6:0]                  wr_ptr   [0:NCH-1];
  logic [6:0]                  rd_ptr   [0:NCH-1];
  logic [10:0]                 fifo_mem [0:NCH*DEPTH-1];
  logic [NCH-1:0]              packet_in_flag_r;
  logic [NCH-1:0]              ovr_r;
  logic [NCH-1:0]              fe_r;
  logic [NCH-1:0]              evt_r;

  function automatic logic ch_ok(input logic [6:0] a);
    return a[6:5] != 2'h0 && a[4:0] != 5'h0 && a[4:0] <= 5'(rx_hdlc_pkg::TRIBS_PER_GROUP);
  endfunction : ch_ok

  function automatic logic [6:0] ch_idx(input logic [6:0] a);
    return 7'(({5'h0, a[6:5]} - 7'h1) * 7'(rx_hdlc_pkg::TRIBS_PER_GROUP)
              + {2'h0, a[4:0]} - 7'h1);
  endfunction : ch_idx

  function automatic logic [7:0] rev8(input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) r[i] = v[7-i];
    return r;
  endfunction : rev8

  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic d,
                                           input logic [1:0] m);
    logic [31:0] r;
    r = c;
    if (m == rx_hdlc_pkg::CRC_32)
      r = {1'b0, c[31:1]} ^ ((c[0] ^ d) ? rx_hdlc_pkg::POLY32 : 32'h0);
    else
      r = {17'h0, c[15:1]} ^ ((c[0] ^ d) ? {16'h0, rx_hdlc_pkg::POLY16} : 32'h0);
    return r;
  endfunction : crc_step

  function automatic logic crc_bad(input logic [31:0] c, input logic [1:0] m);
    case (m)
      rx_hdlc_pkg::CRC_CCITT: return c[15:0] != rx_hdlc_pkg::RES16;
      rx_hdlc_pkg::CRC_32:    return c != rx_hdlc_pkg::RES32;
      default:                return 1'b0;
    endcase
  endfunction : crc_bad

  function automatic logic addr_hit(input logic [7:0] b, input logic [31:0] cf);
    logic [7:0] m;
    m = cf[rx_hdlc_pkg::CFG_MM_BIT] ? 8'hfc : 8'hff;
    return ((b ^ cf[15:8]) & m) == 8'h00 || ((b ^ cf[23:16]) & m) == 8'h00 ||
           ((b ^ cf[31:24]) & m) == 8'h00 || ((b ^ 8'hff) & m) == 8'h00;
  endfunction : addr_hit

  // Receive path: one bit of one channel per cycle
  logic [6:0]             rx_idx;
  logic                   rx_go;
  logic                   rx_b;
  logic                   rx_flag_delineate_enable;
  logic [31:0]            rx_cf;
  rx_hdlc_pkg::chan_ctx_t rc;
  rx_hdlc_pkg::chan_ctx_t nc;
  logic                   rx_push;
  logic                   rx_pop;
  logic [7:0]             rx_byte;
  logic                   rx_we;
  logic [10:0]            rx_wd;
  logic                   rx_full;
  logic                   rx_pk;
  logic                   rx_abort_hit;
  logic                   rx_nomatch;

  always_comb begin
    rx_idx       = ch_idx(rx_channel);
    rx_cf        = cfg_mem[rx_idx];
    rc           = ctx_mem[rx_idx];
    rx_go        = rx_valid && ch_ok(rx_channel) && rx_cf[rx_hdlc_pkg::CFG_EN_BIT];
    rx_b         = rx_bit ^ rx_cf[rx_hdlc_pkg::CFG_INVERT_BIT];
    rx_flag_delineate_enable     = rx_cf[rx_hdlc_pkg::CFG_FLAG_DELINEATE_ENABLE_BIT];
    nc           = rc;
    rx_push      = 1'b0;
    rx_pop       = 1'b0;
    rx_byte      = {rc.pend[6], rc.byte_acc[7:1]};
    rx_we        = 1'b0;
    rx_wd        = 11'h000;
    rx_pk        = 1'b0;
    rx_abort_hit = 1'b0;
    rx_nomatch   = 1'b0;
    if (rx_go && !rx_flag_delineate_enable) begin
      nc.byte_acc = {rx_b, rc.byte_acc[7:1]};
      nc.bit_n    = rc.bit_n + 3'h1;
      rx_we       = rc.bit_n == 3'h7;
      rx_wd       = {rx_hdlc_pkg::PBS_NORMAL, rx_b, rc.byte_acc[7:1]};
    end else if (rx_go && rx_b && rc.ones == 3'h6) begin
      rx_abort_hit = rc.in_frame && rc.storing;
      rx_we        = rx_abort_hit;
      rx_wd        = {rx_hdlc_pkg::PBS_ABORT, 8'h00};
      rx_pk        = rx_abort_hit;
      nc           = '0;
      nc.ones      = 3'h7;
    end else if (rx_go && rx_b) begin
      nc.ones = (rc.ones == 3'h7) ? 3'h7 : rc.ones + 3'h1;
      rx_push = rc.ones != 3'h7;
    end else if (rx_go && rc.ones == 3'h6) begin
      // Closing flag: the last seven pending bits belong to the flag
      if (rc.in_frame && rc.storing && rc.any_bits) begin
        rx_we = 1'b1;
        rx_pk = 1'b1;
        if (rc.bit_n != 3'h0)
          rx_wd = {rx_hdlc_pkg::PBS_NONINT, 8'h00};
        else if (crc_bad(rc.crc, rx_cf[rx_hdlc_pkg::CFG_CRC_LSB +: 2]))
          rx_wd = {rx_hdlc_pkg::PBS_CRCERR, 8'h00};
        else
          rx_wd = {rx_hdlc_pkg::PBS_GOOD, 8'h00};
      end
      nc          = '0;
      nc.in_frame = 1'b1;
      nc.storing  = 1'b1;
      nc.crc      = 32'hffff_ffff;
    end else if (rx_go) begin
      nc.ones = 3'h0;
      rx_push = rc.ones != 3'h5;
    end
    if (rx_push && rc.in_frame) begin
      nc.pend = {rc.pend[5:0], rx_b};
      rx_pop  = rc.pend_n == 3'h7;
      if (!rx_pop)
        nc.pend_n = rc.pend_n + 3'h1;
    end
    if (rx_pop) begin
      nc.crc      = crc_step(rc.crc, rc.pend[6], rx_cf[rx_hdlc_pkg::CFG_CRC_LSB +: 2]);
      nc.byte_acc = rx_byte;
      nc.bit_n    = rc.bit_n + 3'h1;
      nc.any_bits = 1'b1;
      if (rc.bit_n == 3'h7) begin
        nc.got_first = 1'b1;
        rx_nomatch   = !rc.got_first && rx_cf[rx_hdlc_pkg::CFG_MEN_BIT] &&
                       !addr_hit(rev8(rx_byte), rx_cf);
        nc.storing   = rc.storing && !rx_nomatch;
        rx_we        = nc.storing;
        rx_wd        = {rx_hdlc_pkg::PBS_NORMAL, rx_byte};
      end
    end
    rx_full = 7'(wr_ptr[rx_idx] + 7'h1) == rd_ptr[rx_idx];
  end

  // Indirect access decode
  logic [6:0]  acc_idx;
  logic        acc_ok;
  logic        acc_fifo;
  logic        acc_go;
  logic        cfg_wr;
  logic        cfg_rd;
  logic        fifo_rd;
  logic        fifo_empty;
  logic        fifo_last;
  logic        same_ch;
  logic [10:0] head;
  logic [7:0]  head_byte;

  always_comb begin
    acc_idx    = ch_idx(s_r.chsel[6:0]);
    acc_ok     = ch_ok(s_r.chsel[6:0]);
    acc_fifo   = s_r.chsel[rx_hdlc_pkg::CHSEL_FIFO_BIT];
    acc_go     = s_r.acc == rx_hdlc_pkg::ACC_RUN && acc_ok && !(acc_fifo && !s_r.rw);
    cfg_wr     = acc_go && !acc_fifo && !s_r.rw;
    cfg_rd     = acc_go && !acc_fifo && s_r.rw;
    fifo_rd    = acc_go && acc_fifo;
    same_ch    = rx_we && rx_idx == acc_idx;
    fifo_empty = wr_ptr[acc_idx] == rd_ptr[acc_idx];
    fifo_last  = 7'(rd_ptr[acc_idx] + 7'h1) == wr_ptr[acc_idx] && !same_ch;
    head       = fifo_mem[{acc_idx, rd_ptr[acc_idx]}];
    head_byte  = s_r.order ? rev8(head[7:0]) : head[7:0];
  end

  // Control state and bus slave
  logic [NCH-1:0] evt_bus_clr;

  always_comb begin
    s_nxt       = s_r;
    evt_bus_clr = '0;
    if (s_r.acc == rx_hdlc_pkg::ACC_RUN) begin
      // Write with FIFO access selected leaves busy up until the next trigger
      s_nxt.acc = (acc_fifo && !s_r.rw) ? rx_hdlc_pkg::ACC_STUCK
                                        : rx_hdlc_pkg::ACC_IDLE;
    end
    if (cfg_rd) begin
      s_nxt.res      = cfg_mem[acc_idx];
      s_nxt.res_fifo = 1'b0;
    end
    if (cfg_wr)
      s_nxt.res[4:1] = s_r.stage[4:1];
    if (fifo_rd) begin
      s_nxt.res_fifo = 1'b1;
      s_nxt.res      = {16'h0000, 2'h0, fifo_empty || fifo_last, ovr_r[acc_idx],
                        packet_in_flag_r[acc_idx], fifo_empty ? rx_hdlc_pkg::PBS_NORMAL : head[10:8],
                        fifo_empty ? 8'h00 : head_byte};
    end
    if (s_r.ap_wr) begin
      case (s_r.ap_idx)
        rx_hdlc_pkg::IDX_STATUS: begin
          s_nxt.rw  = hwdata[rx_hdlc_pkg::STAT_RW_BIT];
          s_nxt.acc = rx_hdlc_pkg::ACC_RUN;
        end
        rx_hdlc_pkg::IDX_CHSEL: s_nxt.chsel = hwdata[7:0];
        rx_hdlc_pkg::IDX_DATA0: s_nxt.stage[7:0] = hwdata[7:0];
        rx_hdlc_pkg::IDX_DATA1: s_nxt.stage[15:8] = hwdata[7:0];
        rx_hdlc_pkg::IDX_DATA2: s_nxt.stage[23:16] = hwdata[7:0];
        rx_hdlc_pkg::IDX_DATA3: s_nxt.stage[31:24] = hwdata[7:0];
        rx_hdlc_pkg::IDX_ORDER: s_nxt.order = hwdata[0];
        rx_hdlc_pkg::IDX_EVT0:  evt_bus_clr[31:0] = hwdata;
        rx_hdlc_pkg::IDX_EVT1:  evt_bus_clr[63:32] = hwdata;
        rx_hdlc_pkg::IDX_EVT2:  evt_bus_clr[83:64] = hwdata[19:0];
        default: ;
      endcase
    end
    s_nxt.ap_wr  = hsel && hready && htrans[1] && hwrite && haddr[31:12] == 20'h0 &&
                   haddr[1:0] == 2'h0 && hsize == rx_hdlc_pkg::HSIZE_WORD;
    s_nxt.ap_idx = haddr[11:2];
    if (hsel && hready && htrans[1] && !hwrite) begin
      s_nxt.rdata = 32'h0;
      if (haddr[31:12] == 20'h0 && hsize == rx_hdlc_pkg::HSIZE_WORD) begin
        case (haddr[11:2])
          rx_hdlc_pkg::IDX_STATUS:
            s_nxt.rdata = {24'h0, s_r.acc != rx_hdlc_pkg::ACC_IDLE, s_r.rw, 6'h00};
          rx_hdlc_pkg::IDX_CHSEL: s_nxt.rdata = {24'h0, s_r.chsel};
          rx_hdlc_pkg::IDX_DATA0: s_nxt.rdata = {24'h0, s_r.res[7:0]};
          rx_hdlc_pkg::IDX_DATA1:
            s_nxt.rdata = s_r.res_fifo ?
              {24'h0, s_r.acc != rx_hdlc_pkg::ACC_IDLE, s_r.res[14:8]} :
              {24'h0, s_r.res[15:8]};
          rx_hdlc_pkg::IDX_DATA2: s_nxt.rdata = {24'h0, s_r.res[23:16]};
          rx_hdlc_pkg::IDX_DATA3: s_nxt.rdata = {24'h0, s_r.res[31:24]};
          rx_hdlc_pkg::IDX_ORDER: s_nxt.rdata = {31'h0, s_r.order};
          rx_hdlc_pkg::IDX_EVT0:  s_nxt.rdata = evt_r[31:0];
          rx_hdlc_pkg::IDX_EVT1:  s_nxt.rdata = evt_r[63:32];
          rx_hdlc_pkg::IDX_EVT2:  s_nxt.rdata = {12'h000, evt_r[83:64]};
          default: s_nxt.rdata = 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r       <= '0;
      s_r.chsel <= rx_hdlc_pkg::CHSEL_RST;
      s_r.stage <= rx_hdlc_pkg::CFG_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = s_r.rdata;

  // Per-channel flag vectors; a set in the same cycle beats any clear
  logic [NCH-1:0] packet_in_flag_set;
  logic [NCH-1:0] ovr_set;
  logic [NCH-1:0] flag_clr;
  logic [NCH-1:0] evt_clr;
  logic [NCH-1:0] fe_set;
  logic [NCH-1:0] fe_clr;

  always_comb begin
    packet_in_flag_set = '0;
    ovr_set  = '0;
    flag_clr = '0;
    evt_clr  = evt_bus_clr;
    fe_set   = '0;
    fe_clr   = '0;
    packet_in_flag_set[rx_idx] = rx_pk && !rx_full;
    ovr_set[rx_idx]  = rx_we && rx_full;
    fe_clr[rx_idx]   = rx_we && !rx_full;
    if (fifo_rd) begin
      flag_clr[acc_idx] = 1'b1;
      fe_set[acc_idx]   = fifo_empty || fifo_last;
      evt_clr[acc_idx]  = fifo_empty || fifo_last || evt_bus_clr[acc_idx];
    end
    if (cfg_wr && !s_r.stage[rx_hdlc_pkg::CFG_EN_BIT]) begin
      flag_clr[acc_idx] = 1'b1;
      evt_clr[acc_idx]  = 1'b1;
      fe_set[acc_idx]   = 1'b1;
    end
  end

  always_ff @(posedge hclk) begin
    if (rx_we && !rx_full)
      fifo_mem[{rx_idx, wr_ptr[rx_idx]}] <= rx_wd;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < NCH; i++) begin
        ctx_mem[i] <= '0;
        cfg_mem[i] <= rx_hdlc_pkg::CFG_RST;
        wr_ptr[i]  <= 7'h00;
        rd_ptr[i]  <= 7'h00;
      end
      packet_in_flag_r <= '0;
      ovr_r  <= '0;
      fe_r   <= '1;
      evt_r  <= '0;
    end else begin
      packet_in_flag_r <= (packet_in_flag_r & ~flag_clr) | packet_in_flag_set;
      ovr_r  <= (ovr_r & ~flag_clr) | ovr_set;
      fe_r   <= (fe_r & ~fe_clr) | fe_set;
      evt_r  <= (evt_r & ~evt_clr) | packet_in_flag_set | ovr_set;
      if (rx_go)
        ctx_mem[rx_idx] <= nc;
      if (fifo_rd && !fifo_empty)
        rd_ptr[acc_idx] <= rd_ptr[acc_idx] + 7'h1;
      if (cfg_wr) begin
        cfg_mem[acc_idx] <= s_r.stage;
        if (!s_r.stage[rx_hdlc_pkg::CFG_EN_BIT]) begin
          rd_ptr[acc_idx]  <= wr_ptr[acc_idx];
          ctx_mem[acc_idx] <= '0;
        end
      end
      if (rx_we && rx_full)
        rd_ptr[rx_idx] <= wr_ptr[rx_idx];
      else if (rx_we)
        wr_ptr[rx_idx] <= wr_ptr[rx_idx] + 7'h1;
    end
  end

  // Checks
  property p_busy_set;
    @(posedge hclk) disable iff (!hresetn)
      (s_r.ap_wr && s_r.ap_idx == rx_hdlc_pkg::IDX_STATUS) |=> s_r.acc == rx_hdlc_pkg::ACC_RUN;
  endproperty
  a_busy_set: assert property (p_busy_set) else $error("access did not start");

  property p_busy_short;
    @(posedge hclk) disable iff (!hresetn)
      (s_r.acc == rx_hdlc_pkg::ACC_RUN && !(s_r.ap_wr && s_r.ap_idx == rx_hdlc_pkg::IDX_STATUS))
        |=> s_r.acc != rx_hdlc_pkg::ACC_RUN;
  endproperty
  a_busy_short: assert property (p_busy_short) else $error("access ran too long");

  property p_res_hold;
    @(posedge hclk) disable iff (!hresetn)
      !acc_go |=> $stable(s_r.res);
  endproperty
  a_res_hold: assert property (p_res_hold) else $error("read result changed");

  property p_fifo_mode;
    @(posedge hclk) disable iff (!hresetn)
      (acc_go && acc_fifo) |=> s_r.res_fifo ##1 (s_r.res_fifo || $past(cfg_rd));
  endproperty
  a_fifo_mode: assert property (p_fifo_mode) else $error("wrong access target");

  property p_raw_status;
    @(posedge hclk) disable iff (!hresetn)
      (rx_we && !rx_flag_delineate_enable) |-> rx_wd[10:8] == rx_hdlc_pkg::PBS_NORMAL;
  endproperty
  a_raw_status: assert property (p_raw_status) else $error("raw byte status");

  property p_packet_in_flag;
    @(posedge hclk) disable iff (!hresetn)
      (rx_pk && !rx_full) |=> packet_in_flag_r[$past(rx_idx)] && evt_r[$past(rx_idx)];
  endproperty
  a_packet_in_flag: assert property (p_packet_in_flag) else $error("packet-in not raised");

  property p_ovr;
    @(posedge hclk) disable iff (!hresetn)
      (rx_we && rx_full) |=> ovr_r[$past(rx_idx)] &&
                             rd_ptr[$past(rx_idx)] == wr_ptr[$past(rx_idx)];
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun not handled");

  property p_fe;
    @(posedge hclk) disable iff (!hresetn)
      (fifo_rd && fifo_last) |=> s_r.res[rx_hdlc_pkg::RES_FE_BIT] && fe_r[$past(acc_idx)];
  endproperty
  a_fe: assert property (p_fe) else $error("empty flag not returned");

  property p_match;
    @(posedge hclk) disable iff (!hresetn)
      (rx_nomatch && !cfg_wr) |=> !ctx_mem[$past(rx_idx)].storing;
  endproperty
  a_match: assert property (p_match) else $error("unmatched packet stored");
endmodule : rx_hdlc_channel_indirect_access
`default_nettype wire

// file: pkg/rx_hdlc_pkg.sv
// Constants and types for the receive HDLC channel block
package rx_hdlc_pkg;
  localparam int          NUM_CHANNELS    = 84;
  localparam int          TRIBS_PER_GROUP = 28;
  localparam int          FIFO_PTR_W      = 7;
  localparam int          BUSY_MAX_CYCLES = 86;
  // Register indices; byte address is four times the index
  localparam logic [9:0]  IDX_STATUS      = 10'h118;
  localparam logic [9:0]  IDX_CHSEL       = 10'h119;
  localparam logic [9:0]  IDX_DATA0       = 10'h11a;
  localparam logic [9:0]  IDX_DATA1       = 10'h11b;
  localparam logic [9:0]  IDX_DATA2       = 10'h11c;
  localparam logic [9:0]  IDX_DATA3       = 10'h11d;
  localparam logic [9:0]  IDX_ORDER       = 10'h140;
  localparam logic [9:0]  IDX_EVT0        = 10'h141;
  localparam logic [9:0]  IDX_EVT1        = 10'h142;
  localparam logic [9:0]  IDX_EVT2        = 10'h143;
  localparam logic [2:0]  HSIZE_WORD      = 3'h2;
  // Field positions
  localparam int          STAT_BUSY_BIT   = 7;
  localparam int          STAT_RW_BIT     = 6;
  localparam int          CHSEL_FIFO_BIT  = 7;
  localparam int          CFG_EN_BIT      = 0;
  localparam int          CFG_FLAG_DELINEATE_ENABLE_BIT   = 1;
  localparam int          CFG_CRC_LSB     = 2;
  localparam int          CFG_INVERT_BIT  = 4;
  localparam int          CFG_MM_BIT      = 5;
  localparam int          CFG_MEN_BIT     = 6;
  localparam int          RES_FE_BIT      = 13;
  // Reset values
  localparam logic [7:0]  CHSEL_RST       = 8'h00;
  localparam logic [31:0] CFG_RST         = 32'h0000_0000;
  // Byte status codes
  localparam logic [2:0]  PBS_NORMAL      = 3'h0;
  localparam logic [2:0]  PBS_ABORT       = 3'h2;
  localparam logic [2:0]  PBS_GOOD        = 3'h4;
  localparam logic [2:0]  PBS_NONINT      = 3'h5;
  localparam logic [2:0]  PBS_CRCERR      = 3'h6;
  // Check sequence modes and constants (reflected, first bit in lsb)
  localparam logic [1:0]  CRC_CCITT       = 2'h1;
  localparam logic [1:0]  CRC_32          = 2'h2;
  localparam logic [15:0] POLY16          = 16'h8408;
  localparam logic [15:0] RES16           = 16'hf0b8;
  localparam logic [31:0] POLY32          = 32'hedb88320;
  localparam logic [31:0] RES32           = 32'hdebb20e3;

  typedef enum logic [1:0] {
    ACC_IDLE  = 2'h0,
    ACC_RUN   = 2'h1,
    ACC_STUCK = 2'h3
  } acc_state_t;

  typedef struct packed {
    logic [2:0]  ones;
    logic [6:0]  pend;
    logic [2:0]  pend_n;
    logic [7:0]  byte_acc;
    logic [2:0]  bit_n;
    logic [31:0] crc;
    logic        in_frame;
    logic        storing;
    logic        got_first;
    logic        any_bits;
  } chan_ctx_t;
endpackage : rx_hdlc_pkg

// file: dv/link_src.sv
// Behavioural tributary bit source for the receive HDLC block
`timescale 1ns/10ps
`default_nettype none
module link_src (
  input  wire logic  hclk,
  output logic       rx_valid,
  output logic [6:0] rx_channel,
  output logic       rx_bit
);
  int run;
  // Complements the line so an inverting channel still sees flags
  logic inv;
  initial begin
    inv = 1'b0;
    rx_valid = 1'b0;
    rx_channel = 7'h21;
    rx_bit = 1'b0;
    run = 0;
  end
  task automatic put(input logic b);
    @(posedge hclk);
    rx_valid <= 1'b1;
    rx_bit <= b ^ inv;
  endtask : put
  task automatic flag();
    for (int i = 0; i < 8; i++) put(i != 0 && i != 7);
    run = 0;
  endtask : flag
  // Zero after five ones keeps data from looking like a flag
  task automatic data(input logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      put(v[i]);
      run = v[i] ? run + 1 : 0;
      if (run == 5) begin
        put(1'b0);
        run = 0;
      end
    end
  endtask : data
  task automatic ones(input int n);
    for (int i = 0; i < n; i++) put(1'b1);
  endtask : ones
  // Released line shows the inverse so a stale bit is never mistaken for data
  task automatic idle();
    @(posedge hclk);
    rx_valid <= 1'b0;
    rx_bit <= ~rx_bit;
  endtask : idle
endmodule : link_src
`default_nettype wire

// file: dv/rx_hdlc_channel_indirect_access_tb.sv
// Register-level bench for the receive HDLC channel block
`timescale 1ns/10ps
`default_nettype none
module rx_hdlc_channel_indirect_access_tb;
  logic        hclk, hresetn, hsel, hwrite;
  logic [31:0] haddr, hwdata, t;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  wire         hready, hresp, rx_valid, rx_bit;
  wire  [31:0] hrdata;
  wire  [6:0]  rx_channel;
  int          n_mismatch, checked, cyc;
  rx_hdlc_channel_indirect_access rx_hdlc_channel_indirect_access_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .rx_valid(rx_valid),
    .rx_channel(rx_channel), .rx_bit(rx_bit));
  link_src link_src_inst (.hclk(hclk), .rx_valid(rx_valid), .rx_channel(rx_channel),
    .rx_bit(rx_bit));
  always #2 hclk = ~hclk;
  // Whole run needs well under this many cycles
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_mismatch = n_mismatch + 1;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [9:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {20'h0, idx, 2'h0};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic wr(input logic [9:0] idx, input logic [31:0] v);
    logic [31:0] d;
    bus(1'b1, idx, v, d);
  endtask : wr
  // Start an indirect access, then poll busy under a bound
  task automatic acc(input logic [7:0] sel, input logic rw);
    logic [31:0] s;
    wr(rx_hdlc_pkg::IDX_CHSEL, {24'h0, sel});
    wr(rx_hdlc_pkg::IDX_STATUS, {24'h0, 1'b0, rw, 6'h0});
    s = 32'h80;
    for (int i = 0; i < 100 && s[7] !== 1'b0; i++) bus(1'b0, rx_hdlc_pkg::IDX_STATUS, 0, s);
    chk({31'h0, s[7]}, 32'h0);
  endtask : acc
  task automatic cfg(input logic [7:0] c, input logic [7:0] p);
    wr(rx_hdlc_pkg::IDX_DATA0, {24'h0, c});
    wr(rx_hdlc_pkg::IDX_DATA1, {24'h0, p});
    wr(rx_hdlc_pkg::IDX_DATA2, 32'h0);
    wr(rx_hdlc_pkg::IDX_DATA3, 32'h0);
    acc(8'h21, 1'b0);
  endtask : cfg
  task automatic fifo(input logic c0, input logic [7:0] e0, input logic [7:0] e1);
    logic [31:0] d;
    acc(8'ha1, 1'b1);
    bus(1'b0, rx_hdlc_pkg::IDX_DATA0, 0, d);
    if (c0) chk(d, {24'h0, e0});
    bus(1'b0, rx_hdlc_pkg::IDX_DATA1, 0, d);
    chk(d, {24'h0, e1});
  endtask : fifo
  task automatic frm(input logic [7:0] v);
    link_src_inst.flag();
    link_src_inst.data(v);
    link_src_inst.flag();
    link_src_inst.idle();
  endtask : frm
  task automatic tdone(input string name);
    $display("test %s done", name);
  endtask : tdone
  initial begin
    hclk = 0; hresetn = 0; hsel = 0; haddr = 0; htrans = 0;
    hwrite = 0; hsize = rx_hdlc_pkg::HSIZE_WORD; hwdata = 0;
    n_mismatch = 0; checked = 0; cyc = 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, rx_hdlc_pkg::IDX_CHSEL, 0, t);
    chk(t, 32'h0);
    bus(1'b0, 10'h1ff, 0, t);
    chk(t, 32'h0);
    tdone("reset");
    cfg(8'h03, 8'h5a);
    bus(1'b0, rx_hdlc_pkg::IDX_DATA0, 0, t);
    chk(t, 32'h02);
    bus(1'b0, rx_hdlc_pkg::IDX_DATA1, 0, t);
    chk(t, 32'h0);
    tdone("staging");
    frm(8'ha5);
    bus(1'b0, rx_hdlc_pkg::IDX_EVT0, 0, t);
    chk(t & 32'h1, 32'h1);
    fifo(1'b1, 8'ha5, 8'h08);
    fifo(1'b0, 8'h0, 8'h24);
    bus(1'b0, rx_hdlc_pkg::IDX_EVT0, 0, t);
    chk(t & 32'h1, 32'h0);
    tdone("good frame");
    wr(rx_hdlc_pkg::IDX_ORDER, 32'h1);
    frm(8'h35);
    fifo(1'b1, 8'hac, 8'h08);
    fifo(1'b0, 8'h0, 8'h24);
    wr(rx_hdlc_pkg::IDX_ORDER, 32'h0);
    tdone("bit order");
    link_src_inst.flag();
    link_src_inst.data(8'h35);
    // Trailing byte pushes the stored byte out of the flag delay line
    link_src_inst.data(8'h00);
    link_src_inst.ones(7);
    link_src_inst.idle();
    fifo(1'b1, 8'h35, 8'h08);
    fifo(1'b1, 8'h00, 8'h22);
    tdone("abort");
    cfg(8'h13, 8'h00);
    link_src_inst.inv = 1'b1;
    frm(8'h35);
    link_src_inst.inv = 1'b0;
    fifo(1'b1, 8'h35, 8'h08);
    fifo(1'b0, 8'h0, 8'h24);
    tdone("invert");
    // One-byte frames fail both checks; the illegal mode checks nothing
    for (int m = 0; m < 3; m++) begin
      cfg(m == 0 ? 8'h07 : (m == 1 ? 8'h0b : 8'h0f), 8'h00);
      frm(8'h35);
      fifo(1'b1, 8'h35, 8'h08);
      fifo(1'b0, 8'h0, m == 2 ? 8'h24 : 8'h26);
    end
    tdone("check sequence");
    cfg(8'h43, 8'hac);
    frm(8'h36);
    frm(8'h35);
    fifo(1'b1, 8'h35, 8'h08);
    fifo(1'b0, 8'h0, 8'h24);
    cfg(8'h63, 8'haf);
    frm(8'h35);
    fifo(1'b1, 8'h35, 8'h08);
    fifo(1'b0, 8'h0, 8'h24);
    tdone("address match");
    cfg(8'h01, 8'h00);
    link_src_inst.flag();
    link_src_inst.idle();
    fifo(1'b1, 8'h7e, 8'h20);
    for (int i = 0; i < 128; i++) link_src_inst.data(8'h00);
    link_src_inst.idle();
    fifo(1'b0, 8'h0, 8'h30);
    fifo(1'b0, 8'h0, 8'h20);
    tdone("raw and overrun");
    cfg(8'h03, 8'h00);
    frm(8'h35);
    cfg(8'h00, 8'h00);
    cfg(8'h03, 8'h00);
    fifo(1'b0, 8'h0, 8'h20);
    bus(1'b0, rx_hdlc_pkg::IDX_EVT0, 0, t);
    chk(t & 32'h1, 32'h0);
    tdone("disable");
    wr(rx_hdlc_pkg::IDX_CHSEL, 32'ha1);
    wr(rx_hdlc_pkg::IDX_STATUS, 32'h0);
    repeat (20) @(posedge hclk);
    bus(1'b0, rx_hdlc_pkg::IDX_STATUS, 0, t);
    chk(t & 32'hc0, 32'h80);
    acc(8'ha1, 1'b1);
    acc(8'h00, 1'b1);
    bus(1'b0, rx_hdlc_pkg::IDX_DATA1, 0, t);
    chk(t, 32'h20);
    tdone("access control");
    complete_run();
  end
endmodule : rx_hdlc_channel_indirect_access_tb
`default_nettype wire
